// *** src/sts_pkg.sv ***
// Shared constants and types for the status byte and command sequencer.
package sts_pkg;
   localparam int BIT_MEAS = 0;
   localparam int BIT_UNUSED = 1;
   localparam int BIT_ERR = 2;
   localparam int BIT_QUES = 3;
   localparam int BIT_MSG = 4;
   localparam int BIT_EVT = 5;
   localparam int BIT_RQS = 6;
   localparam int BIT_OPER = 7;
   localparam logic [7:0] SRE_RESET = 8'h00;
   localparam logic [7:0] TST_PASS = 8'h00;
   localparam logic [7:0] TST_FAIL = 8'h01;
   localparam logic [1:0] SRC_IMMEDIATE = 2'h0;
   localparam logic [1:0] SRC_BUS = 2'h1;
   localparam logic [15:0] COUNT_DEFAULT = 16'h0001;
   localparam logic [15:0] DELAY_DEFAULT = 16'h0000;
   localparam logic [15:0] READING_RESET = 16'h0000;

   typedef enum logic [3:0] {
      CMD_NONE = 4'h0,
      CMD_STB = 4'h1,
      CMD_TRG = 4'h2,
      CMD_TST = 4'h3,
      CMD_WAI = 4'h4,
      CMD_INIT = 4'h5,
      CMD_CONT_ON = 4'h6,
      CMD_CONT_OFF = 4'h7,
      CMD_ABORT = 4'h8,
      CMD_FETCH = 4'h9,
      CMD_CONF = 4'hA,
      CMD_READ = 4'hB,
      CMD_SRE = 4'hC
   } cmd_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_WAIT = 3'b001,
      ST_RD_ABORT = 3'b010,
      ST_RD_INIT = 3'b011,
      ST_RD_WAIT = 3'b100,
      ST_RD_FETCH = 3'b101
   } seq_state_t;

   // Summary inputs coming from the event registers and queues.
   typedef struct packed {
      logic oper_summary;
      logic event_summary;
      logic msg_avail;
      logic ques_summary;
      logic err_avail;
      logic meas_summary;
   } summary_t;

   // Trigger-layer programming, one entry per layer.
   typedef struct packed {
      logic [1:0] source;
      logic [15:0] count;
      logic [15:0] delay;
   } layer_cfg_t;

   // Setup effects of a configure command.
   typedef struct packed {
      logic [1:0] function_sel;
      logic math_en;
      logic buffer_en;
      logic scan_en;
      logic autozero_default;
      logic acq_normal;
   } setup_t;
endpackage : sts_pkg

// *** src/status_byte_and_command_sequencer.sv ***
// Status byte builder and command sequencer for the instrument bus side.
`timescale 1ns/1ps
module status_byte_and_command_sequencer (
   input wire logic clock, // 50 MHz system clock
   input wire logic reset_n, // Asynchronous reset, active low
   input wire sts_pkg::cmd_t cmd, // Command code from the parser
   input wire logic cmd_valid, // Command offered
   output logic cmd_ready, // Ready to take a command, high in idle
   input wire logic [7:0] cmd_arg, // Argument (enable mask, function)
   input wire sts_pkg::summary_t summary, // Bits from event regs and queues
   input wire logic get_pulse, // Bus group execute trigger
   input wire logic [2:0] layer_src_bus, // Layer control source is bus
   input wire logic model_idle, // Trigger model in idle
   input wire logic pointer_settled, // Model pointer has settled
   input wire logic rom_sum_ok, // ROM checksum result
   input wire logic [15:0] latest_reading, // Latest post-processed reading
   input wire logic reading_new, // New reading available
   output logic [7:0] service_status_summary_byte, // Status byte
   output logic srq, // Service request, level
   output logic [7:0] reply_data, // Queued reply byte
   output logic [15:0] reply_reading, // Reading returned by fetch
   output logic reply_valid, // Reply to enqueue, pulse
   output logic [2:0] layer_trigger, // Bus trigger per layer, pulse
   output logic pretrigger, // Buffer pre-trigger, pulse
   output logic initiate_pulse, // Leave idle, pulse
   output logic abort_pulse, // Go idle or restart, pulse
   output logic continuous_r, // Continuous initiation enabled
   output logic error_pulse, // Init ignored error, pulse
   output sts_pkg::layer_cfg_t [2:0] layer_cfg_r, // Trigger layer setup
   output sts_pkg::setup_t setup_r // Function and option setup
);
   import sts_pkg::*;

   seq_state_t state_r;
   logic [7:0] sre_r;
   logic init_pend_r;
   logic trg_pend_r;
   logic [15:0] reading_r;
   logic overlapped_busy;
   logic take;
   logic [7:0] stb_low;
   logic bus_trig;
   logic ext_trig_s1_r;
   logic ext_trig_s2_r;
   logic ext_trig_d_r;

   assign stb_low = {1'b0, 1'b0, summary.event_summary, summary.msg_avail,
      summary.ques_summary, summary.err_avail, 1'b0,
      summary.meas_summary};

   // Status byte: bits mirror their sources, bit 1 is held at zero, bit 6 is computed here.
   always_comb begin
      service_status_summary_byte = stb_low;
      service_status_summary_byte[BIT_MEAS] = summary.meas_summary;
      service_status_summary_byte[BIT_UNUSED] = 1'b0;
      service_status_summary_byte[BIT_ERR] = summary.err_avail;
      service_status_summary_byte[BIT_QUES] = summary.ques_summary;
      service_status_summary_byte[BIT_MSG] = summary.msg_avail;
      service_status_summary_byte[BIT_EVT] = summary.event_summary;
      service_status_summary_byte[BIT_OPER] = summary.oper_summary;
      service_status_summary_byte[BIT_RQS] =
         |({summary.oper_summary, stb_low[6:0]} & {sre_r[7], sre_r[6:0]}
            & 8'hBF);
   end

   assign srq = service_status_summary_byte[BIT_RQS];

   // The trigger pin is asynchronous to this clock.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         ext_trig_s1_r <= 1'b0;
         ext_trig_s2_r <= 1'b0;
         ext_trig_d_r <= 1'b0;
      end else begin
         ext_trig_s1_r <= get_pulse;
         ext_trig_s2_r <= ext_trig_s1_r;
         ext_trig_d_r <= ext_trig_s2_r;
      end
   end

   assign take = cmd_valid && cmd_ready;
   assign bus_trig = (ext_trig_s2_r && !ext_trig_d_r) ||
      (take && cmd == CMD_TRG);
   // The initiate pulse is registered, so the pending flag lags it by one
   // cycle; counting the pulse closes that gap for wait and read.
   assign overlapped_busy = init_pend_r || trg_pend_r || initiate_pulse;
   assign cmd_ready = (state_r == ST_IDLE);

   // Mask register, cleared at power-up and written by enable command.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         sre_r <= SRE_RESET;
      end else if (take && cmd == CMD_SRE) begin
         sre_r <= cmd_arg & 8'hBD;
      end
   end

   // Pending overlapped operations.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         init_pend_r <= 1'b0;
         trg_pend_r <= 1'b0;
      end else begin
         if (initiate_pulse || (take && cmd == CMD_CONT_ON)) begin
            init_pend_r <= 1'b1;
         end else if (model_idle || abort_pulse) begin
            init_pend_r <= 1'b0;
         end
         if (bus_trig) begin
            trg_pend_r <= 1'b1;
         end else if (pointer_settled) begin
            trg_pend_r <= 1'b0;
         end
      end
   end

   // Sequencer for wait and read.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= ST_IDLE;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (take && cmd == CMD_WAI) begin
                  state_r <= ST_WAIT;
               end else if (take && cmd == CMD_READ) begin
                  state_r <= ST_RD_ABORT;
               end
            end
            ST_WAIT: begin
               if (!overlapped_busy) begin
                  state_r <= ST_IDLE;
               end
            end
            ST_RD_ABORT: state_r <= ST_RD_INIT;
            ST_RD_INIT: state_r <= ST_RD_WAIT;
            ST_RD_WAIT: begin
               if (continuous_r || (!init_pend_r && !initiate_pulse)) begin
                  state_r <= ST_RD_FETCH;
               end
            end
            ST_RD_FETCH: state_r <= ST_IDLE;
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // Trigger model pulses.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         initiate_pulse <= 1'b0;
         abort_pulse <= 1'b0;
         error_pulse <= 1'b0;
         layer_trigger <= 3'h0;
         pretrigger <= 1'b0;
      end else begin
         abort_pulse <= (take && (cmd == CMD_ABORT || cmd == CMD_CONF)) ||
            state_r == ST_RD_ABORT;
         initiate_pulse <= ((take && (cmd == CMD_INIT ||
            cmd == CMD_CONT_ON)) || state_r == ST_RD_INIT) &&
            !continuous_r;
         error_pulse <= ((take && cmd == CMD_INIT) ||
            state_r == ST_RD_INIT) && continuous_r;
         layer_trigger <= bus_trig ? layer_src_bus : 3'h0;
         pretrigger <= bus_trig;
      end
   end

   // Continuous flag and configure setup.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         continuous_r <= 1'b0;
         layer_cfg_r <= '0;
         setup_r <= '0;
      end else if (take && cmd == CMD_CONT_ON) begin
         continuous_r <= 1'b1;
      end else if (take && cmd == CMD_CONT_OFF) begin
         continuous_r <= 1'b0;
      end else if (take && cmd == CMD_CONF) begin
         continuous_r <= 1'b0;
         for (int i = 0; i < 3; i++) begin
            layer_cfg_r[i].source <= SRC_IMMEDIATE;
            layer_cfg_r[i].count <= COUNT_DEFAULT;
            layer_cfg_r[i].delay <= DELAY_DEFAULT;
         end
         setup_r.function_sel <= cmd_arg[1:0];
         setup_r.math_en <= 1'b0;
         setup_r.buffer_en <= 1'b0;
         setup_r.scan_en <= 1'b0;
         setup_r.autozero_default <= 1'b1;
         setup_r.acq_normal <= 1'b1;
      end
   end

   // Last reading held so fetch can repeat it.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         reading_r <= READING_RESET;
      end else if (reading_new) begin
         reading_r <= latest_reading;
      end
   end

   // Replies to queries.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         reply_valid <= 1'b0;
         reply_data <= 8'h00;
         reply_reading <= 16'h0000;
      end else begin
         reply_valid <= 1'b0;
         if (take && cmd == CMD_STB) begin
            reply_valid <= 1'b1;
            reply_data <= service_status_summary_byte;
         end else if (take && cmd == CMD_TST) begin
            reply_valid <= 1'b1;
            reply_data <= rom_sum_ok ? TST_PASS : TST_FAIL;
         end else if ((take && cmd == CMD_FETCH) ||
            state_r == ST_RD_FETCH) begin
            reply_valid <= 1'b1;
            reply_reading <= reading_r;
         end
      end
   end

   chk_wait_holds: assert property (@(posedge clock) disable iff (!reset_n)
      (state_r == ST_WAIT && overlapped_busy) |-> !cmd_ready)
      else $error("command taken while overlapped work pending");
   chk_bit1_zero: assert property (@(posedge clock) disable iff (!reset_n)
      !service_status_summary_byte[BIT_UNUSED])
      else $error("status bit 1 set");
   chk_srq_mask: assert property (@(posedge clock) disable iff (!reset_n)
      srq == |(service_status_summary_byte & sre_r & 8'hBF))
      else $error("service request disagrees with mask");
   chk_read_order: assert property (@(posedge clock) disable iff (!reset_n)
      (state_r == ST_RD_ABORT) |=> (state_r == ST_RD_INIT) ##1
      (state_r == ST_RD_WAIT))
      else $error("read sequence out of order");
   chk_init_error: assert property (@(posedge clock) disable iff (!reset_n)
      (take && cmd == CMD_INIT && continuous_r) |=>
      (error_pulse && !initiate_pulse))
      else $error("initiate under continuous not refused");
   chk_conf_cont: assert property (@(posedge clock) disable iff (!reset_n)
      (take && cmd == CMD_CONF) |=> (!continuous_r && abort_pulse &&
      layer_cfg_r[0].count == COUNT_DEFAULT))
      else $error("configure did not apply defaults");
   chk_tst_code: assert property (@(posedge clock) disable iff (!reset_n)
      (take && cmd == CMD_TST && !rom_sum_ok) |=>
      (reply_valid && reply_data == TST_FAIL))
      else $error("self-test failure code wrong");
   chk_trg_layer: assert property (@(posedge clock) disable iff (!reset_n)
      (take && cmd == CMD_TRG) |=>
      (pretrigger && layer_trigger == $past(layer_src_bus)))
      else $error("bus trigger not routed");
   chk_mask_reset: assert property (@(posedge clock) disable iff (!reset_n)
      $rose(reset_n) |-> sre_r == SRE_RESET)
      else $error("enable mask not cleared");
   chk_wait_release: assert property (@(posedge clock) disable iff (!reset_n)
      (state_r == ST_WAIT && !overlapped_busy) |=> cmd_ready)
      else $error("wait not released after overlapped work");
   chk_read_waits: assert property (@(posedge clock) disable iff (!reset_n)
      (state_r == ST_RD_WAIT && !continuous_r &&
      (init_pend_r || initiate_pulse)) |=> (state_r == ST_RD_WAIT))
      else $error("read fetched before trigger model idle");
   chk_fetch_reply: assert property (@(posedge clock) disable iff (!reset_n)
      (take && cmd == CMD_FETCH) |=>
      (reply_valid && reply_reading == $past(reading_r)))
      else $error("fetch did not return held reading");
   chk_cont_start: assert property (@(posedge clock) disable iff (!reset_n)
      (take && cmd == CMD_CONT_ON && !continuous_r) |=> initiate_pulse)
      else $error("continuous on did not leave idle");
endmodule : status_byte_and_command_sequencer

// *** bench/trig_model_stub.sv ***
// Behavioural trigger model that stands behind the sequencer.
`timescale 1ns/1ps
module trig_model_stub #(
   parameter int BUSY = 10
) (
   input wire logic clock, // System clock
   input wire logic reset_n, // Active-low reset
   input wire logic initiate_pulse, // Leave idle
   input wire logic abort_pulse, // Go idle
   input wire logic [2:0] layer_trigger, // Bus triggers per layer
   input wire logic pretrigger, // Any bus trigger, pulse
   output logic model_idle, // Model in idle
   output logic pointer_settled, // Pointer has settled
   output logic [15:0] latest_reading, // Last finished reading
   output logic reading_new // New reading, pulse
);
   int cnt;
   logic [1:0] trig_q;
   // The model runs BUSY cycles per initiate, then returns to idle.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         cnt <= 0;
         model_idle <= 1'b1;
         latest_reading <= 16'hA000;
         reading_new <= 1'b0;
      end else begin
         reading_new <= 1'b0;
         if (abort_pulse) begin
            cnt <= 0;
            model_idle <= 1'b1;
         end else if (initiate_pulse) begin
            cnt <= BUSY;
            model_idle <= 1'b0;
         end else if (cnt == 1) begin
            cnt <= 0;
            model_idle <= 1'b1;
            latest_reading <= latest_reading + 16'h0001;
            reading_new <= 1'b1;
         end else if (cnt > 1) begin
            cnt <= cnt - 1;
         end
      end
   end
   // The pointer settles two cycles after any bus trigger, also one that
   // no layer listens to, so a wait after it is always released.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         trig_q <= 2'h0;
      end else begin
         trig_q <= {trig_q[0], pretrigger | (|layer_trigger)};
      end
   end
   assign pointer_settled = trig_q[1];
endmodule : trig_model_stub

// *** bench/status_byte_and_command_sequencer_bench.sv ***
// Self-checking bench for the status byte and command sequencer.
`timescale 1ns/1ps
module status_byte_and_command_sequencer_bench;
   import sts_pkg::*;
   logic clock, reset_n, cmd_valid, cmd_ready, get_pulse, model_idle;
   cmd_t cmd;
   logic [7:0] cmd_arg, service_status_summary_byte, reply_data;
   summary_t summary, s;
   logic [2:0] layer_src_bus, layer_trigger, b3;
   logic pointer_settled, rom_sum_ok, reading_new, srq, reply_valid;
   logic [15:0] latest_reading, reply_reading, rep_r, exp_r;
   logic pretrigger, initiate_pulse, abort_pulse, continuous_r, error_pulse;
   layer_cfg_t [2:0] layer_cfg_r;
   setup_t setup_r;
   logic [7:0] rep_d, mask, eb;
   logic got_rep, pre_seen, idle_q;
   logic [2:0] trig_seen;
   int errors, n_tests, seed, k, i, cyc, t_abort, t_init, t_err, t_rep, t_idle;

   status_byte_and_command_sequencer status_byte_and_command_sequencer_inst (
      .clock(clock), .reset_n(reset_n), .cmd(cmd), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd_arg(cmd_arg), .summary(summary),
      .get_pulse(get_pulse), .layer_src_bus(layer_src_bus),
      .model_idle(model_idle), .pointer_settled(pointer_settled),
      .rom_sum_ok(rom_sum_ok), .latest_reading(latest_reading),
      .reading_new(reading_new),
      .service_status_summary_byte(service_status_summary_byte),
      .srq(srq), .reply_data(reply_data), .reply_reading(reply_reading),
      .reply_valid(reply_valid), .layer_trigger(layer_trigger),
      .pretrigger(pretrigger), .initiate_pulse(initiate_pulse),
      .abort_pulse(abort_pulse), .continuous_r(continuous_r),
      .error_pulse(error_pulse), .layer_cfg_r(layer_cfg_r),
      .setup_r(setup_r));
   trig_model_stub trig_model_stub_inst (.clock(clock), .reset_n(reset_n),
      .initiate_pulse(initiate_pulse), .abort_pulse(abort_pulse),
      .layer_trigger(layer_trigger), .pretrigger(pretrigger),
      .model_idle(model_idle), .pointer_settled(pointer_settled),
      .latest_reading(latest_reading), .reading_new(reading_new));

   always #10 clock = ~clock;

   always @(posedge clock) begin
      cyc <= cyc + 1;
      idle_q <= model_idle;
      if (abort_pulse) t_abort <= cyc;
      if (initiate_pulse) t_init <= cyc;
      if (error_pulse) t_err <= cyc;
      if (model_idle && !idle_q) t_idle <= cyc;
      if (pretrigger) pre_seen <= 1'b1;
      trig_seen <= trig_seen | layer_trigger;
      if (reply_valid) begin
         got_rep <= 1'b1;
         rep_d <= reply_data;
         rep_r <= reply_reading;
         exp_r <= latest_reading;
         t_rep <= cyc;
      end
   end

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : complete_run

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic clr();
      {got_rep, pre_seen, trig_seen} = '0;
      {t_abort, t_init, t_err, t_rep, t_idle} = '0;
   endtask : clr

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : wait_cyc

   // Holds the command until the edge that samples cmd_ready high.
   task automatic send(input cmd_t c, input logic [7:0] a);
      wait_cyc(1);
      cmd = c;
      cmd_arg = a;
      cmd_valid = 1'b1;
      for (i = 0; i < 300 && cmd_ready !== 1'b1; i++) wait_cyc(1);
      if (cmd_ready !== 1'b1) begin
         errors++;
         complete_run();
      end
      wait_cyc(1);
      cmd_valid = 1'b0;
   endtask : send

   task automatic wait_reply();
      for (i = 0; i < 100 && !got_rep; i++) wait_cyc(1);
      if (!got_rep) begin
         errors++;
         complete_run();
      end
   endtask : wait_reply

   function automatic logic [7:0] exp_byte(summary_t v, logic [7:0] m);
      logic [7:0] b;
      b = 8'h00;
      b[BIT_MEAS] = v.meas_summary;
      b[BIT_ERR] = v.err_avail;
      b[BIT_QUES] = v.ques_summary;
      b[BIT_MSG] = v.msg_avail;
      b[BIT_EVT] = v.event_summary;
      b[BIT_OPER] = v.oper_summary;
      b[BIT_RQS] = |(b & m);
      return b;
   endfunction : exp_byte

   initial begin
      {clock, reset_n, cmd_valid, get_pulse, cmd_arg, layer_src_bus} = '0;
      {errors, n_tests, cyc} = '0;
      cmd = CMD_NONE;
      summary = '0;
      rom_sum_ok = 1'b1;
      seed = 18701;
      clr();
      repeat (4) @(posedge clock);
      #1;
      reset_n = 1'b1;
      summary = 6'h3F;
      wait_cyc(1);
      chk(srq, 1'b0);
      chk(service_status_summary_byte, 8'hBD);
      $display("test reset done");
      for (k = 0; k < 12; k++) begin
         mask = (k == 0) ? 8'hFF : 8'($random(seed));
         s = summary_t'(6'($random(seed)));
         send(CMD_SRE, mask);
         summary = s;
         clr();
         send(CMD_STB, 8'h00);
         wait_reply();
         eb = exp_byte(s, mask);
         chk(rep_d, eb);
         chk(service_status_summary_byte, eb);
         chk(srq, eb[BIT_RQS]);
      end
      $display("test status byte done");
      for (k = 0; k < 2; k++) begin
         rom_sum_ok = k[0];
         clr();
         send(CMD_TST, 8'h00);
         wait_reply();
         chk(rep_d, k[0] ? TST_PASS : TST_FAIL);
      end
      $display("test self test done");
      for (k = 0; k < 6; k++) begin
         b3 = (k == 0) ? 3'b000 : 3'($random(seed));
         layer_src_bus = b3;
         clr();
         if (k[0]) begin
            send(CMD_TRG, 8'h00);
         end else begin
            get_pulse = 1'b1;
            wait_cyc(3);
            get_pulse = 1'b0;
         end
         send(CMD_WAI, 8'h00);
         wait_cyc(6);
         chk(trig_seen, b3);
         chk(pre_seen, 1'b1);
      end
      $display("test trigger done");
      send(CMD_INIT, 8'h00);
      send(CMD_CONT_ON, 8'h00);
      b3 = 3'($random(seed));
      send(CMD_CONF, {6'h00, b3[1:0]});
      wait_cyc(3);
      chk(model_idle, 1'b1);
      chk(continuous_r, 1'b0);
      chk(setup_r, {b3[1:0], 5'b00011});
      for (k = 0; k < 3; k++) begin
         chk(layer_cfg_r[k], {SRC_IMMEDIATE, COUNT_DEFAULT, DELAY_DEFAULT});
      end
      $display("test configure done");
      send(CMD_CONT_ON, 8'h00);
      wait_cyc(3);
      chk(continuous_r, 1'b1);
      clr();
      send(CMD_INIT, 8'h00);
      wait_cyc(3);
      chk(t_err != 0 && t_init == 0, 1'b1);
      clr();
      send(CMD_READ, 8'h00);
      wait_reply();
      chk(t_abort < t_err && t_err < t_rep, 1'b1);
      chk(rep_r, exp_r);
      $display("test continuous read done");
      send(CMD_CONT_OFF, 8'h00);
      clr();
      send(CMD_INIT, 8'h00);
      send(CMD_WAI, 8'h00);
      send(CMD_FETCH, 8'h00);
      wait_reply();
      chk(t_idle != 0 && t_rep > t_idle, 1'b1);
      chk(rep_r, exp_r);
      clr();
      send(CMD_READ, 8'h00);
      wait_reply();
      chk(t_abort < t_init && t_init < t_idle && t_idle < t_rep, 1'b1);
      chk(rep_r, exp_r);
      eb = rep_r[7:0];
      clr();
      send(CMD_FETCH, 8'h00);
      wait_reply();
      chk(rep_r[7:0], eb);
      $display("test read and wait done");
      complete_run();
   end
endmodule : status_byte_and_command_sequencer_bench
